// ==== src/rhsp_top.sv ====
// host serial port: SPI or two-wire slave with byte-ready handshake
`timescale 1ns/1ps
`default_nettype none
module rhsp_top
    import rhsp_pkg::*;
#(
    parameter logic [15:0] GAP_CYCLES = RHSP_GAP_CYCLES
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic serial_clock,
    input wire logic slave_select_n,
    input wire logic shared_serial_data_line_in,
    output logic shared_serial_data_line_out,
    output logic shared_serial_data_line_oe,
    output logic spi_data_out,
    output logic spi_data_out_oe,
    input wire logic interface_select_strap,
    input wire logic addr_strap,
    output logic byte_ready_handshake,
    input wire logic [7:0] resp_data,
    input wire logic resp_valid,
    output logic resp_taken,
    output logic [7:0] cmd_data,
    output logic cmd_valid,
    output logic host_port_is_spi
);

    // ************************************************************
    // reset and input synchronisers
    // ************************************************************
    logic [1:0] rst_sync_reg;
    logic [4:0] pins_s;
    logic spi_tog_s;
    wire logic rst_n = rst_sync_reg[1];

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    rhsp_sync #(.W(5), .INIT(RHSP_SYNC_INIT)) u_pin_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .d({serial_clock, shared_serial_data_line_in, slave_select_n,
            addr_strap, interface_select_strap}),
        .q(pins_s)
    );

    wire logic scl_s = pins_s[4];
    wire logic sda_s = pins_s[3];
    wire logic ssn_s = pins_s[2];
    wire logic addr_s = pins_s[1];
    wire logic interface_select_strap_s = pins_s[0];

    // ************************************************************
    // strap capture after reset release
    // ************************************************************
    logic [1:0] strap_cnt_reg;
    logic mode_spi_reg;
    logic addr_hi_reg;
    wire logic strap_done = strap_cnt_reg == RHSP_STRAP_WAIT;
    wire logic twi_en = strap_done & ~mode_spi_reg;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_cnt_reg <= 2'h0;
            mode_spi_reg <= 1'b0;
            addr_hi_reg <= 1'b0;
        end
        else if (!strap_done)
        begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            mode_spi_reg <= interface_select_strap_s;
            addr_hi_reg <= addr_s;
        end
    end

    // ************************************************************
    // SPI link, clocked by the host serial clock
    // ************************************************************
    logic [7:0] tx_byte_reg;
    logic [2:0] spi_cnt_reg;
    logic [6:0] spi_sh_reg;
    logic [7:0] spi_byte_reg;
    logic spi_tog_reg;
    logic spi_out_reg;
    logic spi_fell_reg;
    // deselect holds link logic in reset
    wire logic link_rst_n = rst_n & mode_spi_reg & ~slave_select_n;

    always_ff @(posedge serial_clock or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            spi_cnt_reg <= 3'h0;
            spi_sh_reg <= 7'h00;
        end
        else
        begin
            spi_cnt_reg <= spi_cnt_reg + 3'h1;
            spi_sh_reg <= {spi_sh_reg[5:0], shared_serial_data_line_in};
        end
    end

    // whole byte handed over by toggle, survives deselect
    always_ff @(posedge serial_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spi_byte_reg <= 8'h00;
            spi_tog_reg <= 1'b0;
        end
        else if (link_rst_n && spi_cnt_reg == 3'h7)
        begin
            spi_byte_reg <= {spi_sh_reg, shared_serial_data_line_in};
            spi_tog_reg <= ~spi_tog_reg;
        end
    end

    always_ff @(negedge serial_clock or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            spi_out_reg <= 1'b0;
            spi_fell_reg <= 1'b0;
        end
        else
        begin
            spi_out_reg <= tx_byte_reg[3'h7 - spi_cnt_reg];
            spi_fell_reg <= 1'b1;
        end
    end

    // mode 0: first bit shown before any edge
    assign spi_data_out = spi_fell_reg ? spi_out_reg : tx_byte_reg[7];
    assign spi_data_out_oe = link_rst_n;

    rhsp_sync #(.W(1), .INIT(1'b0)) u_tog_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .d(spi_tog_reg),
        .q(spi_tog_s)
    );

    logic spi_tog_d_reg;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            spi_tog_d_reg <= 1'b0;
        else
            spi_tog_d_reg <= spi_tog_s;
    end
    wire logic spi_evt = spi_tog_s ^ spi_tog_d_reg;

    // ************************************************************
    // two-wire slave, oversampled on the internal clock
    // ************************************************************
    rhsp_tw_state_t tw_state_reg, tw_state_next;
    logic [3:0] tw_cnt_reg, tw_cnt_next;
    logic [7:0] tw_sh_reg, tw_sh_next;
    logic [7:0] tw_tx_reg, tw_tx_next;
    logic tw_oe_reg, tw_oe_next;
    logic tw_rd_reg, tw_rd_next;
    logic scl_d_reg;
    logic sda_d_reg;
    logic cmd_ok;

    wire logic scl_rise = scl_s & ~scl_d_reg;
    wire logic scl_fall = ~scl_s & scl_d_reg;
    // start and stop while clock high
    wire logic tw_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire logic tw_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    wire logic [6:0] my_addr = addr_hi_reg ? RHSP_TWI_ADDR_HI
                                           : RHSP_TWI_ADDR_LO;
    wire logic addr_hit = tw_sh_reg[7:1] == my_addr;
    wire logic byte_end = scl_fall && tw_cnt_reg == RHSP_BITS;
    wire logic last_rise = scl_rise && tw_cnt_reg == 4'h7;
    wire logic twi_wr_evt = tw_state_reg == RHSP_TW_WDATA && last_rise;
    wire logic twi_rd_evt = tw_state_reg == RHSP_TW_RDATA && last_rise;
    wire logic [7:0] tw_wr_byte = {tw_sh_reg[6:0], sda_s};

    // bus state and open-drain drive
    always_comb
    begin
        tw_state_next = tw_state_reg;
        tw_cnt_next = tw_cnt_reg;
        tw_sh_next = tw_sh_reg;
        tw_tx_next = tw_tx_reg;
        tw_oe_next = tw_oe_reg;
        tw_rd_next = tw_rd_reg;
        if (scl_rise)
        begin
            tw_sh_next = tw_wr_byte;
            tw_cnt_next = tw_cnt_reg + 4'h1;
        end
        unique case (tw_state_reg)
            RHSP_TW_IDLE:
                tw_oe_next = 1'b0;
            RHSP_TW_ADDR:
                if (byte_end)
                begin
                    tw_state_next = addr_hit ? RHSP_TW_AACK : RHSP_TW_IDLE;
                    tw_oe_next = addr_hit;
                    tw_rd_next = tw_sh_reg[0];
                end
            RHSP_TW_AACK, RHSP_TW_RACK:
                if (scl_fall)
                begin
                    tw_cnt_next = 4'h0;
                    if (tw_state_reg == RHSP_TW_RACK && tw_sh_reg[0])
                    begin
                        tw_state_next = RHSP_TW_IDLE;
                        tw_oe_next = 1'b0;
                    end
                    else if (tw_rd_reg)
                    begin
                        tw_state_next = RHSP_TW_RDATA;
                        tw_tx_next = byte_ready_handshake ? tx_byte_reg
                                                          : 8'hFF;
                        tw_oe_next = byte_ready_handshake & ~tx_byte_reg[7];
                    end
                    else
                    begin
                        tw_state_next = RHSP_TW_WDATA;
                        tw_oe_next = 1'b0;
                    end
                end
            RHSP_TW_WDATA:
                if (byte_end)
                begin
                    tw_state_next = RHSP_TW_WACK;
                    tw_oe_next = tw_rd_reg;
                end
                else if (last_rise)
                    tw_rd_next = cmd_ok;
            RHSP_TW_WACK:
                if (scl_fall)
                begin
                    tw_state_next = RHSP_TW_WDATA;
                    tw_cnt_next = 4'h0;
                    tw_oe_next = 1'b0;
                    tw_rd_next = 1'b0;
                end
            RHSP_TW_RDATA:
                if (byte_end)
                begin
                    tw_state_next = RHSP_TW_RACK;
                    tw_oe_next = 1'b0;
                end
                else if (scl_fall)
                begin
                    tw_tx_next = {tw_tx_reg[6:0], 1'b1};
                    tw_oe_next = ~tw_tx_reg[6];
                end
            default:
                tw_state_next = RHSP_TW_IDLE;
        endcase
        if (!twi_en || tw_stop)
        begin
            tw_state_next = RHSP_TW_IDLE;
            tw_oe_next = 1'b0;
        end
        else if (tw_start)
        begin
            tw_state_next = RHSP_TW_ADDR;
            tw_cnt_next = 4'h0;
            tw_oe_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tw_state_reg <= RHSP_TW_IDLE;
            tw_cnt_reg <= 4'h0;
            tw_sh_reg <= 8'h00;
            tw_tx_reg <= 8'hFF;
            tw_oe_reg <= 1'b0;
            tw_rd_reg <= 1'b0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            tw_state_reg <= tw_state_next;
            tw_cnt_reg <= tw_cnt_next;
            tw_sh_reg <= tw_sh_next;
            tw_tx_reg <= tw_tx_next;
            tw_oe_reg <= tw_oe_next;
            tw_rd_reg <= tw_rd_next;
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign shared_serial_data_line_out = 1'b0;
    assign shared_serial_data_line_oe = tw_oe_reg;

    // ************************************************************
    // response byte and handshake
    // ************************************************************
    rhsp_hs_state_t hs_state_reg, hs_state_next;
    logic [15:0] gap_cnt_reg;
    logic [15:0] gap_len_reg;
    logic hs_reg;
    logic taken_reg;
    logic [7:0] cmd_data_reg;
    logic cmd_valid_reg;

    // SPI loads only while deselected so the link sees a stable byte
    wire logic load_ok = strap_done & (~mode_spi_reg | ssn_s);
    wire logic byte_evt = (spi_evt & mode_spi_reg) | twi_wr_evt | twi_rd_evt;
    wire logic read_done = byte_evt & (hs_state_reg == RHSP_HS_READY) &
                           ~twi_wr_evt;
    assign cmd_ok = hs_state_reg == RHSP_HS_EMPTY;
    // commands only with no response pending
    wire logic cmd_evt = cmd_ok & ((spi_evt & mode_spi_reg) | twi_wr_evt);
    wire logic [7:0] cmd_byte = mode_spi_reg ? spi_byte_reg : tw_wr_byte;
    wire logic load = hs_state_next == RHSP_HS_READY &&
                      hs_state_reg != RHSP_HS_READY;

    always_comb
    begin
        hs_state_next = hs_state_reg;
        unique case (hs_state_reg)
            RHSP_HS_EMPTY:
                if (resp_valid && load_ok)
                    hs_state_next = RHSP_HS_READY;
            // drop after last bit, gap if more
            RHSP_HS_READY:
                if (read_done)
                    hs_state_next = resp_valid ? RHSP_HS_GAP
                                               : RHSP_HS_EMPTY;
            RHSP_HS_GAP:
                if (gap_cnt_reg == 16'h0000 && load_ok)
                    hs_state_next = resp_valid ? RHSP_HS_READY
                                               : RHSP_HS_EMPTY;
            default:
                hs_state_next = RHSP_HS_EMPTY;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            gap_cnt_reg <= 16'h0000;
        else if (read_done)
            gap_cnt_reg <= GAP_CYCLES - 16'h0001;
        else if (gap_cnt_reg != 16'h0000)
            gap_cnt_reg <= gap_cnt_reg - 16'h0001;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hs_state_reg <= RHSP_HS_EMPTY;
            hs_reg <= 1'b0;
            taken_reg <= 1'b0;
            tx_byte_reg <= 8'h00;
            cmd_data_reg <= 8'h00;
            cmd_valid_reg <= 1'b0;
        end
        else
        begin
            hs_state_reg <= hs_state_next;
            hs_reg <= hs_state_next == RHSP_HS_READY;
            taken_reg <= load;
            if (load)
                tx_byte_reg <= resp_data;
            if (cmd_evt)
                cmd_data_reg <= cmd_byte;
            cmd_valid_reg <= cmd_evt;
        end
    end

    assign byte_ready_handshake = hs_reg;
    assign resp_taken = taken_reg;
    assign cmd_data = cmd_data_reg;
    assign cmd_valid = cmd_valid_reg;
    assign host_port_is_spi = mode_spi_reg;

    // ************************************************************
    // checks
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            gap_len_reg <= 16'h0000;
        else if (hs_state_reg == RHSP_HS_GAP)
            gap_len_reg <= gap_len_reg + 16'h0001;
        else
            gap_len_reg <= 16'h0000;
    end

    property p_strap_mode;
        @(posedge mclk) disable iff (!rst_n)
        $rose(strap_done) |-> host_port_is_spi == $past(interface_select_strap_s);
    endproperty
    a_strap_mode: assert property (p_strap_mode)
        else $error("interface mode differs from strap");

    property p_spi_out;
        @(posedge serial_clock) disable iff (!link_rst_n)
        1'b1 |-> spi_data_out == tx_byte_reg[3'h7 - spi_cnt_reg];
    endproperty
    a_spi_out: assert property (p_spi_out)
        else $error("spi output bit wrong at rising edge");

    property p_spi_count;
        @(posedge serial_clock) disable iff (!link_rst_n)
        $past(spi_fell_reg) |-> spi_cnt_reg == $past(spi_cnt_reg) + 3'h1;
    endproperty
    a_spi_count: assert property (p_spi_count)
        else $error("spi bit count did not advance");

    property p_deselect;
        @(posedge mclk) disable iff (!rst_n)
        ssn_s |-> !$past(spi_data_out_oe, 2); // synced select lags two
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("spi output driven while deselected");

    property p_load;
        @(posedge mclk) disable iff (!rst_n)
        resp_taken |-> byte_ready_handshake && tx_byte_reg == $past(resp_data);
    endproperty
    a_load: assert property (p_load)
        else $error("loaded byte not flagged ready");

    property p_gap_start;
        @(posedge mclk) disable iff (!rst_n)
        read_done && resp_valid |=> !byte_ready_handshake ##1
            !byte_ready_handshake;
    endproperty
    a_gap_start: assert property (p_gap_start)
        else $error("no low gap before next byte");

    property p_gap_len;
        @(posedge mclk) disable iff (!rst_n)
        $rose(byte_ready_handshake) && $past(hs_state_reg) == RHSP_HS_GAP
            |-> gap_len_reg >= GAP_CYCLES;
    endproperty
    a_gap_len: assert property (p_gap_len)
        else $error("handshake gap too short");

    property p_read_drop;
        @(posedge mclk) disable iff (!rst_n)
        read_done |=> !byte_ready_handshake;
    endproperty
    a_read_drop: assert property (p_read_drop)
        else $error("handshake high after byte read");

    property p_cmd_refuse;
        @(posedge mclk) disable iff (!rst_n)
        cmd_valid |-> $past(hs_state_reg) == RHSP_HS_EMPTY;
    endproperty
    a_cmd_refuse: assert property (p_cmd_refuse)
        else $error("command taken with response pending");

    property p_addr_ack;
        @(posedge mclk) disable iff (!rst_n)
        tw_state_reg == RHSP_TW_AACK && $past(tw_state_reg) == RHSP_TW_ADDR
            |-> $past(addr_hit) && shared_serial_data_line_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("acknowledge without address match");

    property p_idle_release;
        @(posedge mclk) disable iff (!rst_n)
        tw_state_reg == RHSP_TW_IDLE |-> !shared_serial_data_line_oe;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data line held while idle");

    property p_change_low;
        @(posedge mclk) disable iff (!rst_n)
        $rose(shared_serial_data_line_oe) |-> !scl_s;
    endproperty
    a_change_low: assert property (p_change_low)
        else $error("data line pulled while clock high");

endmodule : rhsp_top
`default_nettype wire

// ==== src/rhsp_pkg.sv ====
// constants and types of the reader host serial port
//
// Functional notes
// - strap high selects SPI slave port
// - strap low selects two-wire slave port
// - SPI slave only, mode 0, clock idles low
// - SPI input bit captured on rising edge
// - SPI output changes on falling edge
// - deselected: ignore link, output high impedance
// - handshake high means response byte ready
// - next byte waiting: handshake low 150 us
// - handshake drops after last bit read
// - no command accepted while response pending
// - master clocks two-wire bus, MSB first
// - sample while clock high, change while low
// - address strap picks 0x50 or 0xD4 address
// - start, then seven-bit address plus direction
// - address match: data line low one bit
// - mismatch: release line, ignore packet
`default_nettype none
package rhsp_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned RHSP_CLK_MHZ = 250;
    localparam int unsigned RHSP_GAP_US = 150;
    localparam logic [15:0] RHSP_GAP_CYCLES = 16'(RHSP_GAP_US * RHSP_CLK_MHZ);
    localparam logic [1:0] RHSP_STRAP_WAIT = 2'h3;

    // ************************************************************
    // two-wire framing, addresses and pin synchroniser reset levels
    // ************************************************************
    localparam logic [3:0] RHSP_BITS = 4'h8;
    localparam logic [6:0] RHSP_TWI_ADDR_LO = 7'h28;
    localparam logic [6:0] RHSP_TWI_ADDR_HI = 7'h6A;
    localparam logic [4:0] RHSP_SYNC_INIT = 5'h1C;

    // ************************************************************
    // state types
    // ************************************************************
    typedef enum logic [1:0] {
        RHSP_HS_EMPTY,
        RHSP_HS_READY,
        RHSP_HS_GAP
    } rhsp_hs_state_t;

    typedef enum logic [2:0] {
        RHSP_TW_IDLE,
        RHSP_TW_ADDR,
        RHSP_TW_AACK,
        RHSP_TW_WDATA,
        RHSP_TW_WACK,
        RHSP_TW_RDATA,
        RHSP_TW_RACK
    } rhsp_tw_state_t;

endpackage : rhsp_pkg
`default_nettype wire

// ==== src/rhsp_sync.sv ====
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none
module rhsp_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : rhsp_sync
`default_nettype wire

// ==== sim/rhsp_host_model.sv ====
// host master model driving the SPI or two-wire link
`timescale 1ns/1ps
`default_nettype none
module rhsp_host_model
(
    output var logic sck,
    output var logic ssn,
    output var logic dout,
    input wire logic miso,
    input wire logic line
);
    logic lclk = 1'b0;
    // free link clock, gated onto sck only in frames
    always #3 lclk = ~lclk;
    initial
    begin
        sck = 1'b0;
        ssn = 1'b1;
        dout = 1'b1;
    end
    task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
        @(posedge lclk);
        ssn <= 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge lclk);
            dout <= tx[i];
            @(posedge lclk);
            sck <= 1'b1;
            rx[i] = miso;
            @(posedge lclk);
            sck <= 1'b0;
        end
        @(posedge lclk);
        ssn <= 1'b1;
        dout <= ~dout; // released line shows no stale value
    endtask : spi_byte
    task automatic tw_bit(input logic b, output logic s);
        @(posedge lclk);
        dout <= b;
        repeat (4) @(posedge lclk);
        sck <= 1'b1;
        repeat (3) @(posedge lclk);
        s = line;
        repeat (2) @(posedge lclk);
        sck <= 1'b0;
    endtask : tw_bit
    task automatic tw_edge(input logic a, input logic z);
        @(posedge lclk);
        dout <= a;
        repeat (4) @(posedge lclk);
        sck <= 1'b1;
        repeat (4) @(posedge lclk);
        dout <= z;
        repeat (4) @(posedge lclk);
        sck <= z; // a start leaves the clock low
    endtask : tw_edge
    task automatic tw_byte(input logic [7:0] tx, input logic mack,
        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            tw_bit(tx[i], rx[i]);
        tw_bit(mack, ack);
    endtask : tw_byte
endmodule : rhsp_host_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench of the host serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    err_count++; \
    $display("unexpected at %0t: %0h vs %0h", $time, a, e); end end
`define WAITC(c) begin for (n = 0; n < 3000 && !(c); n++) \
    @(negedge mclk); if (!(c)) begin err_count++; conclude(); end end
module tb_top;
    import rhsp_pkg::*;
    localparam int GAP = 20;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic strap = 1'b1;
    logic addr_strap = 1'b0;
    logic [7:0] resp_data = 8'h00;
    logic resp_valid = 1'b0;
    logic [7:0] rq[$];
    wire logic sck, ssn, dout, miso, line, sdo, sdo_oe, oe, hs, taken;
    wire logic line_out;
    wire logic cmd_valid, is_spi;
    wire logic [7:0] cmd_data;
    int err_count = 0;
    int samples_checked = 0;
    int n, cmd_cnt = 0, lowcnt = 0, lastlow = 0;
    always #2 mclk = ~mclk;
    // open-drain line and tristated spi output
    assign line = dout & (~oe | line_out);
    assign miso = sdo_oe ? sdo : ~sdo;
    rhsp_host_model host (.sck, .ssn, .dout, .miso, .line);
    rhsp_top #(.GAP_CYCLES(16'(GAP))) dut (.mclk, .resetn,
        .serial_clock(sck), .slave_select_n(ssn),
        .shared_serial_data_line_in(line),
        .shared_serial_data_line_out(line_out),
        .shared_serial_data_line_oe(oe), .spi_data_out(sdo),
        .spi_data_out_oe(sdo_oe), .interface_select_strap(strap),
        .addr_strap, .byte_ready_handshake(hs), .resp_data, .resp_valid,
        .resp_taken(taken), .cmd_data, .cmd_valid, .host_port_is_spi(is_spi));
    // response source, next byte after each take
    always @(posedge mclk)
    begin
        if (taken === 1'b1)
            void'(rq.pop_front());
        resp_valid <= (rq.size() != 0);
        resp_data <= (rq.size() != 0) ? rq[0] : 8'h00;
    end
    // command count and handshake low runs
    always @(posedge mclk)
    begin
        if (cmd_valid === 1'b1)
            cmd_cnt++;
        if (hs !== 1'b1)
            lowcnt++;
        else if (lowcnt != 0)
        begin
            lastlow = lowcnt;
            lowcnt = 0;
        end
    end
    // drive changes only with clock low
    always @(oe)
        if (resetn === 1'b1 && is_spi === 1'b0)
            `CHK(sck, 1'b0)
    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    task automatic do_reset(input logic s, input logic a);
        @(posedge mclk);
        resetn <= 1'b0;
        strap <= s;
        addr_strap <= a;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
    endtask : do_reset
    task automatic tw_xfer(input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] rx, output logic aa, output logic ad);
        host.tw_edge(1'b1, 1'b0);
        host.tw_byte(a, 1'b1, rx, aa);
        host.tw_byte(d, 1'b1, rx, ad);
        host.tw_edge(1'b0, 1'b1);
    endtask : tw_xfer
    task automatic t_spi;
        logic [7:0] rx;
        int c;
        do_reset(1'b1, 1'b0);
        `CHK(is_spi, 1'b1)
        `CHK(sdo_oe, 1'b0)
        c = cmd_cnt;
        host.spi_byte(8'hA5, rx);
        `WAITC(cmd_cnt == c + 1)
        `CHK(cmd_data, 8'hA5)
        rq.push_back(8'h3C);
        rq.push_back(8'hC3);
        `WAITC(hs === 1'b1)
        host.spi_byte(8'h00, rx);
        `CHK(rx, 8'h3C)
        repeat (8) @(negedge mclk);
        `CHK(hs, 1'b0)
        `WAITC(hs === 1'b1)
        host.spi_byte(8'h00, rx);
        `CHK(rx, 8'hC3)
        repeat (8) @(negedge mclk);
        `CHK(hs, 1'b0)
        `CHK(cmd_cnt, c + 1)
        $display("test spi done");
    endtask : t_spi
    task automatic t_tw(input logic s);
        logic [7:0] good;
        logic [7:0] rx;
        logic aa;
        logic ad;
        int c;
        good = s ? 8'hD4 : 8'h50;
        do_reset(1'b0, s);
        `CHK(is_spi, 1'b0)
        c = cmd_cnt;
        tw_xfer(good ^ 8'h84, 8'h96, rx, aa, ad);
        `CHK({aa, ad}, 2'h3)
        tw_xfer(good, 8'h5A, rx, aa, ad);
        `CHK({aa, ad}, 2'h0)
        `CHK(cmd_data, 8'h5A)
        `CHK(cmd_cnt, c + 1)
        rq.push_back(8'h81);
        rq.push_back(8'h18);
        `WAITC(hs === 1'b1)
        tw_xfer(good | 8'h01, 8'hFF, rx, aa, ad);
        `CHK(rx, 8'h81)
        tw_xfer(good, 8'h33, rx, aa, ad);
        `CHK({aa, ad}, 2'h1)
        `CHK(lastlow, GAP)
        tw_xfer(good | 8'h01, 8'hFF, rx, aa, ad);
        `CHK(rx, 8'h18)
        `CHK(hs, 1'b0)
        $display("test two-wire %0d done", s);
    endtask : t_tw
    initial
    begin
        t_spi();
        t_tw(1'b0);
        t_tw(1'b1);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
